// ===== core/cmd_interp.sv
// calibration unlock, display message and phase selection command state behind an apb slave
// assumes apb master signals synchronous to ref_clk; harmonic coefficients arrive from measurement calibration
// Functional notes
// - unlock turns calibration mode on and switches the level loop off
// - enabling the level loop clears calibration mode unless unlock is set in the same write
// - ac high range full scale coefficient, 0 to 65535, readable
// - dc high range full scale coefficient, 0 to 65535, readable
// - signed dc high range offset coefficient, -2000 to +2000, readable
// - seven harmonic coefficients readable, set only by measurement calibration
// - message buffer 8 rows of 40 characters; excess text discarded
// - no padding or length checking of message rows
// - display off blanks characters in every view; reset leaves display on
// - view normal, text or measurement; resets to normal; message shown only in text view
// - measurement view reverts to first screen after 3 s without bus activity
// - message resets empty; query returns last programmed string
// - cursor row 1..8, column 1..40; text past row end truncated
// - coupled programming hits all phases, uncoupled only the selected one
// - coupling commands ignored in single phase configuration
// - numeric select 1,2,3 means phase a,b,c
// - letter select a,b,c sets the same selected phase
// - selections recorded while coupled take effect on uncoupling
// - measurement phase is always the selected phase alone
// - coefficient writes refused without unlock; queries still allowed
module cmd_interp
  import cmd_pkg::*;
#(
  parameter longint unsigned IDLE_CYCLES = IDLE_CYCLES_DOC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // configuration and measurement calibration results
  input wire logic three_phase,
  input wire logic harm_load,
  input wire logic [2:0] harm_load_idx,
  input wire logic [15:0] harm_load_data,
  // display and output control
  output status_t status
);
  typedef struct packed {
    logic rdy;
    logic err;
    logic [31:0] rdata;
    status_t st;
    logic [2:0] harm_idx;
    logic [8:0] text_idx;
    logic [3:0] row;
    logic [5:0] col;
    logic [2:0][15:0] ac_fs;
    logic [2:0][15:0] dc_fs;
    logic [2:0][15:0] dc_zero;
    logic [HARM_N-1:0][15:0] harm;
    logic [31:0] idle;
    logic [CHARS-1:0][7:0] text;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic access;
  logic wr;
  logic rd;
  logic [2:0] ph_idx;
  logic [8:0] put_idx;
  logic signed [15:0] zero_w;
  logic [3:0] new_row;
  logic [5:0] new_col;
  logic [31:0] idle_lim;

  assign access = psel && penable && !s_r.rdy;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign ph_idx = (s_r.st.phase_sel == PH_A) ? 3'd0 : (s_r.st.phase_sel == PH_B) ? 3'd1 : 3'd2;
  assign put_idx = 9'((32'(s_r.row) - 32'd1) * COLS + (32'(s_r.col) - 32'd1));
  assign zero_w = signed'(pwdata[15:0]);
  assign new_row = pwdata[CURSOR_ROW +: 4];
  assign new_col = pwdata[5:0];
  // a revert needs at least one idle cycle to count
  assign idle_lim = (IDLE_CYCLES > 1) ? 32'(IDLE_CYCLES - 1) : 32'd1;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdy = access;
    s_nxt.err = 1'b0;
    s_nxt.rdata = '0;
    s_nxt.st.revert_meas1 = 1'b0;
    if (wr)
    begin
      unique case (paddr)
        OFS_CTRL:
        begin
          if (pwdata[CTRL_LOOP] && !s_r.st.level_loop_on)
            s_nxt.st.cal_mode = 1'b0;
          s_nxt.st.level_loop_on = pwdata[CTRL_LOOP];
          if (pwdata[CTRL_UNLOCK])
          begin
            s_nxt.st.cal_mode = 1'b1;
            s_nxt.st.level_loop_on = 1'b0;
          end
          s_nxt.st.display_on = pwdata[CTRL_DISP];
          if (pwdata[CTRL_VIEW +: 2] == VIEW_NORMAL || pwdata[CTRL_VIEW +: 2] == VIEW_TEXT ||
              pwdata[CTRL_VIEW +: 2] == VIEW_MEAS)
            s_nxt.st.view = view_t'(pwdata[CTRL_VIEW +: 2]);
          else
            s_nxt.err = 1'b1;
          if (three_phase)
            s_nxt.st.coupled = pwdata[CTRL_COUP];
        end
        OFS_PHASE_NUM:
        begin
          unique case (pwdata)
            32'h0000_0001: s_nxt.st.phase_sel = PH_A;
            32'h0000_0002: s_nxt.st.phase_sel = PH_B;
            32'h0000_0003: s_nxt.st.phase_sel = PH_C;
            default: s_nxt.err = 1'b1;
          endcase
        end
        OFS_PHASE_LET:
        begin
          unique case (pwdata)
            32'h0000_0041: s_nxt.st.phase_sel = PH_A;
            32'h0000_0042: s_nxt.st.phase_sel = PH_B;
            32'h0000_0043: s_nxt.st.phase_sel = PH_C;
            default: s_nxt.err = 1'b1;
          endcase
        end
        OFS_AC_FS, OFS_DC_FS, OFS_DC_ZERO:
        begin
          if (!s_r.st.cal_mode)
            s_nxt.err = 1'b1;
          else if (paddr == OFS_DC_ZERO && (pwdata[31:16] != {16{pwdata[15]}} ||
                   zero_w < ZERO_MIN || zero_w > ZERO_MAX))
            s_nxt.err = 1'b1;
          else if (paddr != OFS_DC_ZERO && pwdata[31:16] != 16'h0000)
            s_nxt.err = 1'b1;
          else
          begin
            for (int p = 0; p < 3; p++)
            begin
              if (s_r.st.prog_phase_mask[p])
              begin
                if (paddr == OFS_AC_FS)
                  s_nxt.ac_fs[p] = pwdata[15:0];
                else if (paddr == OFS_DC_FS)
                  s_nxt.dc_fs[p] = pwdata[15:0];
                else
                  s_nxt.dc_zero[p] = pwdata[15:0];
              end
            end
          end
        end
        OFS_HARM_SEL:
        begin
          if (pwdata < HARM_N)
            s_nxt.harm_idx = pwdata[2:0];
          else
            s_nxt.err = 1'b1;
        end
        OFS_CURSOR:
        begin
          if (new_row >= 4'd1 && new_row <= 4'(ROWS) && new_col >= 6'd1 && new_col <= 6'(COLS))
          begin
            s_nxt.row = new_row;
            s_nxt.col = new_col;
          end
          else
            s_nxt.err = 1'b1;
        end
        OFS_TEXT:
        begin
          // no wrap into the next row: the host formats every row itself
          if (s_r.col <= 6'(COLS))
          begin
            s_nxt.text[put_idx] = pwdata[7:0];
            s_nxt.col = s_r.col + 6'd1;
          end
        end
        OFS_TEXT_CLR:
        begin
          s_nxt.text = '0;
          s_nxt.row = 4'd1;
          s_nxt.col = 6'd1;
        end
        OFS_TEXT_IDX:
        begin
          if (pwdata < CHARS)
            s_nxt.text_idx = pwdata[8:0];
          else
            s_nxt.err = 1'b1;
        end
        default: s_nxt.err = 1'b1;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        OFS_CTRL: s_nxt.rdata = 32'({s_r.st.coupled, 2'b00, s_r.st.view, 1'b0, s_r.st.display_on,
                                     s_r.st.level_loop_on, s_r.st.cal_mode});
        OFS_PHASE_NUM: s_nxt.rdata = 32'(ph_idx) + 32'd1;
        OFS_PHASE_LET: s_nxt.rdata = 32'h0000_0041 + 32'(ph_idx);
        OFS_AC_FS: s_nxt.rdata = 32'(s_r.ac_fs[ph_idx]);
        OFS_DC_FS: s_nxt.rdata = 32'(s_r.dc_fs[ph_idx]);
        OFS_DC_ZERO: s_nxt.rdata = 32'(signed'(s_r.dc_zero[ph_idx]));
        OFS_HARM_SEL: s_nxt.rdata = 32'(s_r.harm_idx);
        OFS_HARM_DATA: s_nxt.rdata = 32'(s_r.harm[s_r.harm_idx]);
        OFS_CURSOR: s_nxt.rdata = 32'({s_r.row, 2'b00, s_r.col});
        OFS_TEXT_IDX: s_nxt.rdata = 32'(s_r.text_idx);
        OFS_TEXT_RD: s_nxt.rdata = 32'(s_r.text[s_r.text_idx]);
        default: s_nxt.err = 1'b1;
      endcase
    end
    // the only writer of harmonic coefficients is the measurement calibration
    if (harm_load && harm_load_idx < HARM_N)
      s_nxt.harm[harm_load_idx] = harm_load_data;
    // idle timer for the measurement view
    if (psel || s_r.st.view != VIEW_MEAS)
      s_nxt.idle = '0;
    else if (s_r.idle < idle_lim)
      s_nxt.idle = s_r.idle + 32'd1;
    s_nxt.st.revert_meas1 = (s_r.st.view == VIEW_MEAS) && !psel && (s_r.idle == idle_lim - 32'd1);
    s_nxt.st.char_blank = !s_nxt.st.display_on;
    s_nxt.st.show_text = s_nxt.st.display_on && s_nxt.st.view == VIEW_TEXT;
    s_nxt.st.prog_phase_mask = s_nxt.st.coupled ? 3'b111 :
      (s_nxt.st.phase_sel == PH_A) ? 3'b001 : (s_nxt.st.phase_sel == PH_B) ? 3'b010 : 3'b100;
    s_nxt.st.meas_phase_mask = (s_nxt.st.phase_sel == PH_A) ? 3'b001 :
      (s_nxt.st.phase_sel == PH_B) ? 3'b010 : 3'b100;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.st.display_on <= RST_DISP_ON;
      s_r.st.view <= VIEW_NORMAL;
      s_r.st.phase_sel <= PH_A;
      s_r.st.prog_phase_mask <= 3'b001;
      s_r.st.meas_phase_mask <= 3'b001;
      s_r.row <= 4'd1;
      s_r.col <= 6'd1;
      s_r.ac_fs <= {3{RST_COEFF}};
      s_r.dc_fs <= {3{RST_COEFF}};
      s_r.dc_zero <= {3{RST_COEFF}};
      s_r.text <= '0;
    end
    else
      s_r <= s_nxt;
  end

  assign pready = s_r.rdy;
  assign prdata = s_r.rdata;
  assign pslverr = s_r.err;
  assign status = s_r.st;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_write(logic [7:0] a);
    wr && paddr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    rd && paddr == a;
  endsequence

  sequence s_answer;
    pready && !pslverr;
  endsequence

  sequence s_put;
    s_write(OFS_TEXT) ##0 (s_r.col <= 6'(COLS));
  endsequence

  // uncoupling only counts where coupling commands are honoured at all
  sequence s_uncouple;
    s_write(OFS_CTRL) ##0 (three_phase && !pwdata[CTRL_COUP] && status.coupled);
  endsequence

  AST_UNLOCK: assert property (s_write(OFS_CTRL) ##0 pwdata[CTRL_UNLOCK] |=> status.cal_mode && !status.level_loop_on)
    else $error("unlock did not enter calibration with loop off");
  AST_LOOP_CLEARS_CAL: assert property (s_write(OFS_CTRL) ##0 (pwdata[CTRL_LOOP] && !pwdata[CTRL_UNLOCK] &&
                                         !status.level_loop_on) |=> !status.cal_mode)
    else $error("loop enable left calibration mode on");
  AST_REFUSED: assert property (s_write(OFS_AC_FS) ##0 !status.cal_mode |=> $stable(s_r.ac_fs) && pslverr)
    else $error("locked coefficient write changed state");
  AST_ZERO_RANGE: assert property (signed'(s_r.dc_zero[0]) >= ZERO_MIN && signed'(s_r.dc_zero[0]) <= ZERO_MAX)
    else $error("offset coefficient out of range");
  AST_BLANK: assert property (s_write(OFS_CTRL) ##0 !pwdata[CTRL_DISP] |=> status.char_blank && !status.show_text)
    else $error("display off did not blank the characters");
  AST_SHOW_TEXT: assert property (status.show_text |-> status.view == VIEW_TEXT && status.display_on)
    else $error("message shown outside text view");
  AST_SINGLE: assert property (!three_phase && wr |=> $stable(status.coupled))
    else $error("coupling changed in single phase");
  AST_NSEL_B: assert property (s_write(OFS_PHASE_NUM) ##0 pwdata == 32'd2 |=> status.phase_sel == PH_B)
    else $error("numeric select 2 did not pick phase b");
  AST_COUPLED_MASK: assert property (status.coupled |-> status.prog_phase_mask == 3'b111)
    else $error("coupled programming not on all phases");
  AST_MEAS_ONEHOT: assert property ($onehot(status.meas_phase_mask))
    else $error("measurement phase not a single phase");
  AST_REVERT: assert property (status.revert_meas1 |-> status.view == VIEW_MEAS ##1 !status.revert_meas1)
    else $error("revert outside measurement view or not a pulse");
  AST_ROW_END: assert property (s_write(OFS_TEXT) ##0 s_r.col > 6'(COLS) |=> $stable(s_r.text))
    else $error("text past row end was stored");
  // refusals are judged one edge after the access, where pslverr stands
  AST_DC_REFUSED: assert property (s_write(OFS_DC_FS) ##0 !status.cal_mode |=> $stable(s_r.dc_fs) && pslverr)
    else $error("locked dc coefficient write changed state");
  AST_ZERO_REFUSED: assert property (s_write(OFS_DC_ZERO) ##0 !status.cal_mode |=>
    $stable(s_r.dc_zero) && pslverr)
    else $error("locked offset write changed state");
  AST_LOCKED_READ: assert property (s_read(OFS_AC_FS) ##0 !status.cal_mode |=> s_answer)
    else $error("locked coefficient query refused");
  AST_FS_RANGE: assert property (s_write(OFS_DC_FS) ##0 (pwdata[31:16] != 16'h0000) |=>
    $stable(s_r.dc_fs) && pslverr)
    else $error("oversized full scale value accepted");
  AST_ZERO_REJECT: assert property (s_write(OFS_DC_ZERO) ##0
    (signed'(pwdata) > ZERO_MAX || signed'(pwdata) < ZERO_MIN) |=> $stable(s_r.dc_zero) && pslverr)
    else $error("offset outside range accepted");
  AST_PHASE_REJECT: assert property (s_write(OFS_PHASE_NUM) ##0 (pwdata == 32'h0 || pwdata > 32'h3) |=>
    $stable(status.phase_sel) && pslverr)
    else $error("bad numeric phase accepted");
  AST_LETTER_REJECT: assert property (s_write(OFS_PHASE_LET) ##0 (pwdata < 32'h41 || pwdata > 32'h43) |=>
    $stable(status.phase_sel) && pslverr)
    else $error("bad phase letter accepted");
  AST_ROW_REJECT: assert property (s_write(OFS_CURSOR) ##0 (new_row == 4'd0 || new_row > 4'(ROWS)) |=>
    $stable(s_r.row) && pslverr)
    else $error("bad cursor row accepted");
  AST_COL_REJECT: assert property (s_write(OFS_CURSOR) ##0 (new_col == 6'd0 || new_col > 6'(COLS)) |=>
    $stable(s_r.col) && pslverr)
    else $error("bad cursor column accepted");
  AST_IDX_REJECT: assert property (s_write(OFS_TEXT_IDX) ##0 (pwdata >= CHARS) |=>
    $stable(s_r.text_idx) && pslverr)
    else $error("text index beyond capacity accepted");
  AST_CURSOR_SET: assert property (s_write(OFS_CURSOR) ##0
    (new_row >= 4'd1 && new_row <= 4'(ROWS) && new_col >= 6'd1 && new_col <= 6'(COLS)) |=>
    s_r.row == $past(new_row) && s_r.col == $past(new_col))
    else $error("valid cursor not taken");
  AST_COLUMN_ADVANCE: assert property (s_put |=> s_r.col == $past(s_r.col) + 6'd1)
    else $error("cursor did not advance after a character");
  AST_NSEL_A: assert property (s_write(OFS_PHASE_NUM) ##0 (pwdata == 32'd1) |=> status.phase_sel == PH_A)
    else $error("numeric select 1 did not pick phase a");
  AST_NSEL_C: assert property (s_write(OFS_PHASE_NUM) ##0 (pwdata == 32'd3) |=> status.phase_sel == PH_C)
    else $error("numeric select 3 did not pick phase c");
  AST_LETTER_A: assert property (s_write(OFS_PHASE_LET) ##0 (pwdata == 32'h41) |=> status.phase_sel == PH_A)
    else $error("letter a did not pick phase a");
  AST_COUPLE_ALL: assert property (s_write(OFS_CTRL) ##0 (three_phase && pwdata[CTRL_COUP]) |=>
    status.prog_phase_mask == 3'b111)
    else $error("coupling did not reach all phases");
  AST_UNCOUPLE: assert property (s_uncouple |=> status.prog_phase_mask == status.meas_phase_mask)
    else $error("uncoupling did not restore the last selection");
  // harmonic state may move only through the load port
  AST_HARM_BUS: assert property (!harm_load |=> $stable(s_r.harm))
    else $error("harmonic coefficient changed without a load");
  AST_HARM_LOAD: assert property (harm_load && harm_load_idx == 3'd0 |=> s_r.harm[0] == $past(harm_load_data))
    else $error("harmonic load not stored");
  AST_CLEAR: assert property (s_write(OFS_TEXT_CLR) |=> s_r.text == '0 && s_r.row == 4'd1 && s_r.col == 6'd1)
    else $error("message clear incomplete");
  AST_READ_FS: assert property (s_read(OFS_AC_FS) |=> s_answer ##0 prdata[31:16] == 16'h0000)
    else $error("ac coefficient query out of range");
  AST_READ_DC: assert property (s_read(OFS_DC_FS) |=> s_answer ##0 prdata[31:16] == 16'h0000)
    else $error("dc coefficient query out of range");
  AST_READ_ZERO: assert property (s_read(OFS_DC_ZERO) |=> s_answer ##0 prdata[31:16] == {16{prdata[15]}})
    else $error("offset query not sign extended");
  AST_BAD_VIEW: assert property (s_write(OFS_CTRL) ##0 (pwdata[CTRL_VIEW +: 2] == 2'b10) |=>
    $stable(status.view) && pslverr)
    else $error("unknown view code accepted");
  AST_VIEW_TEXT: assert property (s_write(OFS_CTRL) ##0 (pwdata[CTRL_VIEW +: 2] == 2'b01 && pwdata[CTRL_DISP]) |=>
    status.show_text)
    else $error("text view did not show the message");
  AST_REVERT_IDLE: assert property (status.revert_meas1 |-> s_r.idle == idle_lim)
    else $error("revert before the idle time ran out");
endmodule : cmd_interp

// ===== shared/cmd_pkg.sv
// command interpreter constants, register map and state carriers
// assumes one 200 MHz clock and an apb slave port with 32-bit data
package cmd_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned IDLE_SECONDS = 3;
  localparam longint unsigned IDLE_CYCLES_DOC = longint'(IDLE_SECONDS) * CLK_HZ;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PHASE_NUM = 8'h04;
  localparam logic [7:0] OFS_PHASE_LET = 8'h08;
  localparam logic [7:0] OFS_AC_FS = 8'h0c;
  localparam logic [7:0] OFS_DC_FS = 8'h10;
  localparam logic [7:0] OFS_DC_ZERO = 8'h14;
  localparam logic [7:0] OFS_HARM_SEL = 8'h18;
  localparam logic [7:0] OFS_HARM_DATA = 8'h1c;
  localparam logic [7:0] OFS_CURSOR = 8'h20;
  localparam logic [7:0] OFS_TEXT = 8'h24;
  localparam logic [7:0] OFS_TEXT_CLR = 8'h28;
  localparam logic [7:0] OFS_TEXT_IDX = 8'h2c;
  localparam logic [7:0] OFS_TEXT_RD = 8'h30;

  localparam int unsigned CTRL_UNLOCK = 0;
  localparam int unsigned CTRL_LOOP = 1;
  localparam int unsigned CTRL_DISP = 2;
  localparam int unsigned CTRL_VIEW = 4;
  localparam int unsigned CTRL_COUP = 8;
  localparam int unsigned CURSOR_ROW = 8;

  localparam int unsigned ROWS = 8;
  localparam int unsigned COLS = 40;
  localparam int unsigned CHARS = ROWS * COLS;
  localparam int unsigned HARM_N = 7;
  localparam logic [15:0] FS_MAX = 16'hffff;
  localparam logic signed [15:0] ZERO_MIN = -16'sd2000;
  localparam logic signed [15:0] ZERO_MAX = 16'sd2000;

  localparam logic [15:0] RST_COEFF = 16'h0000;
  localparam logic RST_DISP_ON = 1'b1;

  typedef enum logic [1:0] {VIEW_NORMAL = 2'b00, VIEW_TEXT = 2'b01, VIEW_MEAS = 2'b11} view_t;
  typedef enum logic [1:0] {PH_A = 2'b00, PH_B = 2'b01, PH_C = 2'b11} phase_t;

  typedef struct packed {
    logic cal_mode;
    logic level_loop_on;
    logic display_on;
    logic char_blank;
    view_t view;
    logic show_text;
    logic coupled;
    phase_t phase_sel;
    logic [2:0] prog_phase_mask;
    logic [2:0] meas_phase_mask;
    logic revert_meas1;
  } status_t;
endpackage : cmd_pkg

// ===== testbench/apb_host.sv
// host controller model: apb master issuing command writes and queries
// assumes xfer is entered just after a rising edge, from one process only
module apb_host
(
  // clock
  input wire logic ref_clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // request held until pready is sampled high; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output int n);
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows inverted leftovers so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host

// ===== testbench/instrument_cal_display_phase_cmds_bench.sv
// self-checking bench for the command interpreter: host model, queued expectations, monitor
// assumes idle revert shortened to 20 cycles; harmonic results loaded through the load port
module instrument_cal_display_phase_cmds_bench
  import cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst, three_phase, harm_load, psel, penable, pwrite, pready, pslverr;
  logic [2:0] harm_load_idx;
  logic [15:0] harm_load_data;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] hv [7];
  logic [33:0] exp_q [$];
  logic [33:0] nt;
  status_t status;
  int n_fail = 0;
  int checked = 0;
  int k;

  always #2.5 ref_clk = ~ref_clk;

  cmd_interp #(.IDLE_CYCLES(20)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .three_phase(three_phase), .harm_load(harm_load), .harm_load_idx(harm_load_idx),
    .harm_load_data(harm_load_data), .status(status));
  apb_host host_u (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready));

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic complete_run;
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // note {read check, error, data}, then let one edge pass so requests never collide
  task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] xd,
    input logic xe);
    int waited;
    exp_q.push_back({~w, xe, xd});
    host_u.xfer(w, a, d, waited);
    // one wait state: pready in the second access cycle
    cmp("access_cycles", 32'd2, 32'(waited));
    @(posedge ref_clk);
  endtask : go

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    go(1'b1, a, d, 32'h0, xe);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] xd);
    go(1'b0, a, 32'h0, xd, 1'b0);
  endtask : rd

  always @(posedge ref_clk)
    if (pready === 1'b1)
    begin
      nt = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h1_ffff_ffff;
      cmp("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
      if (nt[33])
        cmp("prdata", nt[31:0], prdata);
    end

  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    sys_rst = 1'b1;
    three_phase = 1'b1;
    harm_load = 1'b0;
    harm_load_idx = 3'h0;
    harm_load_data = 16'h0000;
    void'($urandom(35));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    cmp("char_blank", 32'h0, status.char_blank);
    rd(OFS_CTRL, 32'h4);
    rd(OFS_TEXT_RD, 32'h0);
    // measurement calibration results land before the level loop is relied on
    for (int i = 0; i < 7; i++)
    begin
      hv[i] = 16'($urandom);
      harm_load <= 1'b1;
      harm_load_idx <= 3'(i);
      harm_load_data <= hv[i];
      @(posedge ref_clk);
    end
    harm_load <= 1'b0;
    wr(OFS_AC_FS, 32'h1234, 1'b1);
    wr(OFS_DC_FS, 32'h5, 1'b1);
    wr(OFS_DC_ZERO, 32'h5, 1'b1);
    rd(OFS_AC_FS, 32'h0);
    wr(OFS_CTRL, 32'h105, 1'b0);
    cmp("cal_mode", 32'h1, status.cal_mode);
    wr(OFS_CTRL, 32'h106, 1'b0);
    rd(OFS_CTRL, 32'h106);
    wr(OFS_AC_FS, 32'h1, 1'b1);
    wr(OFS_CTRL, 32'h107, 1'b0);
    rd(OFS_CTRL, 32'h105);
    v = $urandom_range(65535);
    wr(OFS_AC_FS, v, 1'b0);
    wr(OFS_DC_FS, 32'hffff, 1'b0);
    wr(OFS_DC_ZERO, -2000, 1'b0);
    wr(OFS_DC_FS, 32'h10000, 1'b1);
    wr(OFS_DC_ZERO, 2001, 1'b1);
    wr(OFS_PHASE_NUM, 32'h2, 1'b0);
    cmp("prog_mask", 32'h7, status.prog_phase_mask);
    cmp("meas_mask", 32'h2, status.meas_phase_mask);
    wr(OFS_CTRL, 32'h005, 1'b0);
    cmp("prog_mask", 32'h2, status.prog_phase_mask);
    for (int p = 1; p <= 3; p++)
    begin
      wr(OFS_PHASE_NUM, p, 1'b0);
      rd(OFS_PHASE_LET, 32'h40 + p);
      cmp("meas_mask", 32'h1 << (p - 1), status.meas_phase_mask);
      rd(OFS_AC_FS, v);
      rd(OFS_DC_FS, 32'hffff);
      rd(OFS_DC_ZERO, -2000);
    end
    // uncoupled write reaches phase c only
    wr(OFS_AC_FS, v ^ 32'hffff, 1'b0);
    wr(OFS_PHASE_LET, 32'h41, 1'b0);
    rd(OFS_AC_FS, v);
    wr(OFS_PHASE_NUM, 32'h0, 1'b1);
    wr(OFS_PHASE_NUM, 32'h4, 1'b1);
    wr(OFS_PHASE_LET, 32'h44, 1'b1);
    rd(OFS_PHASE_NUM, 32'h1);
    three_phase <= 1'b0;
    wr(OFS_CTRL, 32'h105, 1'b0);
    cmp("coupled", 32'h0, status.coupled);
    for (int i = 0; i < 7; i++)
    begin
      wr(OFS_HARM_SEL, i, 1'b0);
      rd(OFS_HARM_DATA, hv[i]);
    end
    wr(OFS_HARM_SEL, 32'h7, 1'b1);
    wr(OFS_TEXT_CLR, 32'h0, 1'b0);
    wr(OFS_CURSOR, 32'h0827, 1'b0);
    wr(OFS_TEXT, 32'h58, 1'b0);
    wr(OFS_TEXT, 32'h59, 1'b0);
    wr(OFS_TEXT, 32'h5a, 1'b0);
    wr(OFS_TEXT_IDX, 318, 1'b0);
    rd(OFS_TEXT_RD, 32'h58);
    wr(OFS_TEXT_IDX, 319, 1'b0);
    rd(OFS_TEXT_RD, 32'h59);
    wr(OFS_TEXT_IDX, 0, 1'b0);
    rd(OFS_TEXT_RD, 32'h0);
    wr(OFS_TEXT_IDX, 320, 1'b1);
    wr(OFS_CURSOR, 32'h0901, 1'b1);
    wr(OFS_CURSOR, 32'h0129, 1'b1);
    wr(OFS_CURSOR, 32'h0100, 1'b1);
    rd(OFS_CURSOR, 32'h829);
    wr(OFS_CTRL, 32'h015, 1'b0);
    cmp("show_text", 32'h1, status.show_text);
    wr(OFS_CTRL, 32'h011, 1'b0);
    cmp("char_blank", 32'h1, status.char_blank);
    cmp("show_text", 32'h0, status.show_text);
    wr(OFS_CTRL, 32'h025, 1'b1);
    wr(OFS_CTRL, 32'h035, 1'b0);
    k = 0;
    repeat (17)
    begin
      @(posedge ref_clk);
      k += status.revert_meas1;
    end
    cmp("early_revert", 32'h0, k);
    repeat (13)
    begin
      @(posedge ref_clk);
      k += status.revert_meas1;
    end
    cmp("revert_count", 32'h1, k);
    complete_run();
  end
endmodule : instrument_cal_display_phase_cmds_bench
